// ### design/cose_defines.svh
// Constants for the clock output sync and enable control block
`ifndef COSE_DEFINES_SVH
`define COSE_DEFINES_SVH

// ---------------------------------------------------------------
// Serial word layout
// ---------------------------------------------------------------
`define COSE_WORD_W 32
`define COSE_ADDR_W 4
`define COSE_DATA_W 28
`define COSE_ADDR_MSB 3
`define COSE_DATA_LSB 4

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define COSE_NUM_OUT 8
`define COSE_ADDR_GLOBAL 4'he
`define COSE_ADDR_VCO 4'hf

// ---------------------------------------------------------------
// Data field positions, per-output registers (addresses 0..7)
// ---------------------------------------------------------------
`define COSE_F_EN 0
`define COSE_F_SRC_LSB 1
`define COSE_F_SRC_MSB 2
`define COSE_F_DIV_LSB 3
`define COSE_F_DIV_MSB 10

// ---------------------------------------------------------------
// Data field positions, global and VCO registers
// ---------------------------------------------------------------
`define COSE_F_GEN 0
`define COSE_F_VDIV_LSB 0
`define COSE_F_VDIV_MSB 3
`define COSE_F_VPATH 4
`define COSE_F_ZDLY 5

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define COSE_VDIV_RST 4'h2
`define COSE_VDIV_MIN 4'h2
`define COSE_SYNC_DLY 5
`define COSE_DIV_W 8

`endif

// ### design/cose_pkg.sv
// Types shared by the clock output sync and enable control block
package cose_pkg;

    typedef enum logic [1:0] {
        COSE_SRC_BYPASS = 2'b00,
        COSE_SRC_DIV = 2'b01,
        COSE_SRC_DLY = 2'b10,
        COSE_SRC_DIV_DLY = 2'b11
    } cose_src_t;

    typedef enum logic [1:0] {
        COSE_ST_OFF = 2'b00,
        COSE_ST_LOW = 2'b01,
        COSE_ST_RUN = 2'b10
    } cose_state_t;

    typedef struct packed {
        logic en;
        cose_src_t src;
        logic [7:0] div;
    } cose_chan_cfg_t;

    typedef struct packed {
        logic [3:0] vco_divide_value;
        logic vco_path;
        logic zero_dly;
    } cose_vco_cfg_t;

endpackage

// ### design/cose_chan.sv
// One output channel divider with sync hold and realign
`timescale 1ns/1ns
`include "cose_defines.svh"

module cose_chan (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic hold,
    input wire logic [`COSE_DIV_W-1:0] half,
    output logic wave
);

    logic [`COSE_DIV_W-1:0] cnt_ff;
    logic run_ff;
    logic wave_ff;

    assign wave = wave_ff;

    // ---------------------------------------------------------------
    // Divider: toggles every half period of distribution ticks
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            wave_ff <= 1'b0;
        end
        else if (hold)
        begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            wave_ff <= 1'b0;
        end
        else if (tick)
        begin
            if (!run_ff)
            begin
                run_ff <= 1'b1;
                wave_ff <= 1'b1;
                cnt_ff <= '0;
            end
            else if (cnt_ff == half - 8'h01)
            begin
                cnt_ff <= '0;
                wave_ff <= ~wave_ff;
            end
            else
            begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end

endmodule

// ### design/cose_ctrl.sv
// Serial programming, output gating and sync for eight clock outputs
`timescale 1ns/1ns
`include "cose_defines.svh"


module cose_ctrl (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic SERIAL_CLOCK_LINE,
    input wire logic SERIAL_DATA_LINE,
    input wire logic LATCH_ENABLE_LINE,
    input wire logic GLOBAL_OUTPUT_ENABLE_PIN,
    input wire logic SYNC_B,
    output logic [`COSE_NUM_OUT-1:0] CLKOUT,
    output logic [`COSE_NUM_OUT-1:0] CLKOUT_OFF,
    output logic CAL_START
);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [1:0] sck_s_ff;
    logic [1:0] sdat_s_ff;
    logic [1:0] le_s_ff;
    logic [1:0] goe_s_ff;
    logic [1:0] sync_s_ff;
    logic sck_d_ff;
    logic le_d_ff;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sck_s_ff <= 2'h0;
            sdat_s_ff <= 2'h0;
            le_s_ff <= 2'h0;
            goe_s_ff <= 2'h3;
            sync_s_ff <= 2'h3;
            sck_d_ff <= 1'b0;
            le_d_ff <= 1'b0;
        end
        else
        begin
            sck_s_ff <= {sck_s_ff[0], SERIAL_CLOCK_LINE};
            sdat_s_ff <= {sdat_s_ff[0], SERIAL_DATA_LINE};
            le_s_ff <= {le_s_ff[0], LATCH_ENABLE_LINE};
            goe_s_ff <= {goe_s_ff[0], GLOBAL_OUTPUT_ENABLE_PIN};
            sync_s_ff <= {sync_s_ff[0], SYNC_B};
            sck_d_ff <= sck_s_ff[1];
            le_d_ff <= le_s_ff[1];
        end
    end

    logic sck_rise;
    logic le_rise;
    assign sck_rise = sck_s_ff[1] & ~sck_d_ff;
    assign le_rise = le_s_ff[1] & ~le_d_ff;

    // ---------------------------------------------------------------
    // Serial shift register
    // ---------------------------------------------------------------
    logic [`COSE_WORD_W-1:0] shift_ff;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            shift_ff <= '0;
        else if (sck_rise)
            shift_ff <= {shift_ff[`COSE_WORD_W-2:0], sdat_s_ff[1]};
    end

    logic [`COSE_ADDR_W-1:0] wr_addr;
    logic [`COSE_DATA_W-1:0] wr_data;
    assign wr_addr = shift_ff[`COSE_ADDR_MSB:0];
    assign wr_data = shift_ff[`COSE_WORD_W-1:`COSE_DATA_LSB];

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    cose_pkg::cose_chan_cfg_t chan_cfg_ff [`COSE_NUM_OUT];
    cose_pkg::cose_vco_cfg_t vco_cfg_ff;
    logic glob_en_ff;

    genvar gi;
    generate
        for (gi = 0; gi < `COSE_NUM_OUT; gi = gi + 1)
        begin : g_cfg
            always_ff @(posedge CLK or negedge RST_B)
            begin
                if (!RST_B)
                    chan_cfg_ff[gi] <= '0;
                else if (le_rise && wr_addr == gi[`COSE_ADDR_W-1:0])
                begin
                    chan_cfg_ff[gi].en <= wr_data[`COSE_F_EN];
                    chan_cfg_ff[gi].src <= cose_pkg::cose_src_t'(
                        wr_data[`COSE_F_SRC_MSB:`COSE_F_SRC_LSB]);
                    chan_cfg_ff[gi].div <=
                        wr_data[`COSE_F_DIV_MSB:`COSE_F_DIV_LSB];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            glob_en_ff <= 1'b0;
        else if (le_rise && wr_addr == `COSE_ADDR_GLOBAL)
            glob_en_ff <= wr_data[`COSE_F_GEN];
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            vco_cfg_ff <= '0;
            vco_cfg_ff.vco_divide_value <= `COSE_VDIV_RST;
        end
        else if (le_rise && wr_addr == `COSE_ADDR_VCO)
        begin
            vco_cfg_ff.vco_divide_value <= wr_data[`COSE_F_VDIV_MSB:`COSE_F_VDIV_LSB];
            vco_cfg_ff.vco_path <= wr_data[`COSE_F_VPATH];
            vco_cfg_ff.zero_dly <= wr_data[`COSE_F_ZDLY];
        end
    end

    // ---------------------------------------------------------------
    // Calibration trigger
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            CAL_START <= 1'b0;
        else
            CAL_START <= le_rise && wr_addr == `COSE_ADDR_VCO
                && !wr_data[`COSE_F_ZDLY];
    end

    // ---------------------------------------------------------------
    // VCO divider: distribution tick and bypassed waveform
    // ---------------------------------------------------------------
    logic [3:0] vdiv;
    logic [3:0] vhigh;
    logic [3:0] vcnt_ff;
    logic tick;
    logic vwave;

    // Path select set means divider bypass: tick every clock
    always_comb
    begin
        if (vco_cfg_ff.vco_path)
            vdiv = 4'h1;
        else if (vco_cfg_ff.vco_divide_value < `COSE_VDIV_MIN)
            vdiv = `COSE_VDIV_MIN;
        else
            vdiv = vco_cfg_ff.vco_divide_value;
        vhigh = (vdiv == 4'h1) ? 4'h1 : (vdiv >> 1);
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            vcnt_ff <= 4'h0;
        else if (vcnt_ff >= vdiv - 4'h1)
            vcnt_ff <= 4'h0;
        else
            vcnt_ff <= vcnt_ff + 4'h1;
    end

    assign tick = (vcnt_ff == 4'h0);
    assign vwave = (vcnt_ff < vhigh);

    // ---------------------------------------------------------------
    // Sync delay pipeline on distribution ticks
    // ---------------------------------------------------------------
    logic [`COSE_SYNC_DLY-1:0] sync_pipe_ff;
    logic hold;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            sync_pipe_ff <= '1;
        else if (vco_cfg_ff.vco_path)
            sync_pipe_ff <= '1;
        else if (tick)
            sync_pipe_ff <= {sync_pipe_ff[`COSE_SYNC_DLY-2:0],
                sync_s_ff[1]};
    end

    assign hold = ~sync_pipe_ff[`COSE_SYNC_DLY-1];

    // ---------------------------------------------------------------
    // Output channels and gating
    // ---------------------------------------------------------------
    generate
        for (gi = 0; gi < `COSE_NUM_OUT; gi = gi + 1)
        begin : g_out
            logic dwave;
            logic [`COSE_DIV_W-1:0] half;
            logic is_div;
            cose_pkg::cose_state_t st;

            assign half = (chan_cfg_ff[gi].div == 8'h00) ?
                8'h01 : chan_cfg_ff[gi].div;
            assign is_div = chan_cfg_ff[gi].src == cose_pkg::COSE_SRC_DIV
                || chan_cfg_ff[gi].src == cose_pkg::COSE_SRC_DIV_DLY;

            cose_chan u_chan (
                .clk(CLK),
                .rst_b(RST_B),
                .tick(tick),
                .hold(hold),
                .half(half),
                .wave(dwave)
            );

            always_comb
            begin
                if (!chan_cfg_ff[gi].en || !glob_en_ff)
                    st = cose_pkg::COSE_ST_OFF;
                else if (!goe_s_ff[1])
                    st = cose_pkg::COSE_ST_LOW;
                else
                    st = cose_pkg::COSE_ST_RUN;
            end

            always_ff @(posedge CLK or negedge RST_B)
            begin
                if (!RST_B)
                begin
                    CLKOUT[gi] <= 1'b0;
                    CLKOUT_OFF[gi] <= 1'b1;
                end
                else
                begin
                    CLKOUT_OFF[gi] <= (st == cose_pkg::COSE_ST_OFF);
                    if (st != cose_pkg::COSE_ST_RUN)
                        CLKOUT[gi] <= 1'b0;
                    else
                        CLKOUT[gi] <= is_div ? dwave : vwave;
                end
            end
        end
    endgenerate

endmodule

// ### sim/cose_chk.sv
// Port assertions for the clock output control block
`timescale 1ns/1ns
module cose_chk (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic SERIAL_CLOCK_LINE,
    input wire logic SERIAL_DATA_LINE,
    input wire logic LATCH_ENABLE_LINE,
    input wire logic GLOBAL_OUTPUT_ENABLE_PIN,
    input wire logic SYNC_B,
    input wire logic [7:0] CLKOUT,
    input wire logic [7:0] CLKOUT_OFF,
    input wire logic CAL_START
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    AST_CAL_ONE: assert property (
        CAL_START |=> !CAL_START)
        else $error("calibration pulse too long");
    AST_CAL_SRC: assert property (
        CAL_START |-> $past(LATCH_ENABLE_LINE, 2))
        else $error("calibration pulse without latch");
    AST_CAL_IDLE: assert property (
        !LATCH_ENABLE_LINE [*8] |-> !CAL_START)
        else $error("calibration pulse while latch idle");
    AST_RST_OFF: assert property (
        $rose(RST_B) |-> CLKOUT_OFF == 8'hff && CLKOUT == 8'h00)
        else $error("outputs not off after reset");
    AST_OFF_QUIET: assert property (
        (CLKOUT & CLKOUT_OFF & $past(CLKOUT_OFF)) == 8'h00)
        else $error("output toggles in off state");
    AST_OFF_WRITE: assert property (
        $changed(CLKOUT_OFF) |-> $past(LATCH_ENABLE_LINE, 2))
        else $error("off state changed without a write");
    AST_GOE_LOW: assert property (
        !GLOBAL_OUTPUT_ENABLE_PIN [*6] |-> CLKOUT == 8'h00)
        else $error("output runs with enable pin low");
    AST_GOE_KEEP: assert property (
        $fell(GLOBAL_OUTPUT_ENABLE_PIN) |=> $stable(CLKOUT_OFF) [*4])
        else $error("enable pin changed the off state");
endmodule

// ### sim/cose_host.sv
// Host model driving the three-wire programming port
`timescale 1ns/1ns
module cose_host (
    output logic sck,
    output logic sdat,
    output logic le
);
    initial
    begin
        sck = 1'b0;
        sdat = 1'b0;
        le = 1'b0;
    end
    // Clock period 125 ns, data moves while the clock is low
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            sdat = w[i];
            #30 sck = 1'b1;
            #62 sck = 1'b0;
            #33;
        end
        #30 le = 1'b1;
        #60 le = 1'b0;
        sdat = 1'b0;
        // Idle gap keeps the data line from changing twice in one step
        #40;
    endtask
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the clock output control block
`timescale 1ns/1ns
module tb_top;
    logic CLK;
    logic RST_B;
    logic SERIAL_CLOCK_LINE;
    logic SERIAL_DATA_LINE;
    logic LATCH_ENABLE_LINE;
    logic GLOBAL_OUTPUT_ENABLE_PIN;
    logic SYNC_B;
    logic [7:0] CLKOUT;
    logic [7:0] CLKOUT_OFF;
    logic CAL_START;
    logic [7:0] en;
    int n_fail, checked, n_cal, h, k;
    cose_ctrl u_dut (.*);
    cose_host u_host (
        .sck(SERIAL_CLOCK_LINE),
        .sdat(SERIAL_DATA_LINE),
        .le(LATCH_ENABLE_LINE)
    );
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    always @(posedge CLK)
        if (CAL_START === 1'b1)
            n_cal++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic cnt(input int i, input int n);
        h = 0;
        repeat (n)
        begin
            cyc(1);
            if (CLKOUT[i] === 1'b1)
                h++;
        end
    endtask
    // High cycles of an undivided output over twelve VCO periods
    function automatic int hi_exp(input int n);
        return 12 * (n / 2);
    endfunction
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ---------
    // Sequence
    // ---------
    initial
    begin
        RST_B = 1'b0;
        GLOBAL_OUTPUT_ENABLE_PIN = 1'b1;
        SYNC_B = 1'b1;
        n_fail = 0;
        checked = 0;
        n_cal = 0;
        void'($urandom(32'h7c5af1c7));
        cyc(6);
        RST_B = 1'b1;
        cyc(2);
        chk(CLKOUT_OFF, 8'hff);
        chk(CLKOUT, 8'h00);
        u_host.send(32'h1e);
        en = 8'h0f | 8'($urandom);
        for (int c = 0; c < 8; c++)
            u_host.send({17'h0, 8'(c < 4 ? c : 1 + $urandom % 4),
                2'(c < 4 ? c : $urandom), en[c], 4'(c)});
        cyc(10);
        chk(CLKOUT_OFF, 8'(~en));
        for (int n = 8; n >= 2; n--)
        begin
            u_host.send({22'h0, 2'b00, 4'(n), 4'hf});
            cyc(40);
            chk(n_cal, 9 - n);
            for (int i = 0; i < 4; i++)
            begin
                cnt(i, 12 * n);
                chk(h, i % 2 ? 6 * n : hi_exp(n));
            end
        end
        SYNC_B = 1'b0;
        cyc(20);
        chk(CLKOUT & 8'h0a, 8'h00);
        cnt(0, 8);
        chk(h, 4);
        SYNC_B = 1'b1;
        k = 0;
        while (CLKOUT[1] !== 1'b1 && k < 40)
        begin
            cyc(1);
            k++;
        end
        chk(CLKOUT[3], 1'b1);
        chk(k >= 8 && k <= 20, 1'b1);
        if (k == 40)
            end_of_test;
        // Short sync pulse: release after six clocks, before the hold reaches the outputs
        SYNC_B = 1'b0;
        cyc(6);
        SYNC_B = 1'b1;
        cyc(10);
        chk(CLKOUT & 8'h0a, 8'h00);
        k = 0;
        while (CLKOUT[1] !== 1'b1 && k < 40)
        begin
            cyc(1);
            k++;
        end
        chk(CLKOUT[3], 1'b1);
        chk(k <= 8, 1'b1);
        if (k == 40)
            end_of_test;
        u_host.send({22'h0, 2'b11, 4'h2, 4'hf});
        cyc(10);
        chk(n_cal, 7);
        SYNC_B = 1'b0;
        cyc(20);
        cnt(1, 8);
        chk(h, 4);
        SYNC_B = 1'b1;
        GLOBAL_OUTPUT_ENABLE_PIN = 1'b0;
        cyc(8);
        chk(CLKOUT, 8'h00);
        chk(CLKOUT_OFF, 8'(~en));
        GLOBAL_OUTPUT_ENABLE_PIN = 1'b1;
        cyc(8);
        u_host.send({28'($urandom), 4'h9});
        cyc(10);
        chk(CLKOUT_OFF, 8'(~en));
        u_host.send(32'he);
        cyc(10);
        chk(CLKOUT_OFF, 8'hff);
        chk(n_cal, 7);
        end_of_test;
    end
endmodule
bind cose_ctrl cose_chk u_chk (.*);
